// ---- core/dsar_pkg.sv ----
// Purpose: Shared constants and types for the accumulator back end
// Assumes: 32-bit AXI4-Lite register bus, 40-bit accumulators
// Notes: Register offsets are byte addresses
`default_nettype none
package dsar_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_ACCA_LO = 8'h08;
  localparam logic [7:0] ADDR_ACCA_HI = 8'h0C;
  localparam logic [7:0] ADDR_ACCB_LO = 8'h10;
  localparam logic [7:0] ADDR_ACCB_HI = 8'h14;
  localparam logic [7:0] ADDR_WBPTR = 8'h18;
  // Control register fields
  localparam int CTRL_W = 6;
  localparam int CTL_CLIPA = 0;
  localparam int CTL_CLIPB = 1;
  localparam int CTL_WIDTH = 2;
  localparam int CTL_STCLIP = 3;
  localparam int CTL_RNDSTY = 4;
  localparam int CTL_TRAP = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // Status register fields
  localparam int ST_CLIPA = 0;
  localparam int ST_CLIPB = 1;
  localparam int ST_GRDA = 2;
  localparam int ST_GRDB = 3;
  localparam int ST_ANYGRD = 4;
  localparam int ST_ANYCLIP = 5;
  // Saturation limits, rounding tie, write-back step, shift limit and bus responses
  localparam logic [39:0] ACC_MAX40 = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] ACC_MIN40 = 40'h80_0000_0000;
  localparam logic [39:0] ACC_MAX32 = 40'h00_7FFF_FFFF;
  localparam logic [39:0] ACC_MIN32 = 40'hFF_8000_0000;
  localparam logic [15:0] LOW_HALF = 16'h8000;
  localparam logic [15:0] WORD_MAX = 16'h7FFF;
  localparam logic [15:0] WORD_MIN = 16'h8000;
  localparam logic [15:0] WB_STEP = 16'h0002;
  localparam logic [5:0] SHIFT_MAX = 6'h10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Operations from the decoder
  typedef enum logic [2:0] {
    OP_MAC = 3'h0, OP_MPY = 3'h1, OP_MPYN = 3'h2, OP_ED = 3'h3,
    OP_DIFF_SQUARE_ACCUMULATE_OP = 3'h4, OP_SAC = 3'h5, OP_SACR = 3'h6, OP_SHIFT = 3'h7
  } dsar_op_e;
  // Shifter sources
  typedef enum logic [1:0] {
    SH_ACCA = 2'h0, SH_ACCB = 2'h1, SH_XBUS = 2'h2
  } dsar_shsrc_e;
endpackage
`default_nettype wire

// ---- core/dsar_core.sv ----
// Purpose: Accumulator saturation, write-back, rounding, store clip, shifter
// Assumes: Decoder ports are on mclk_in; one operation per cycle
// Notes: Registers reached over AXI4-Lite
// Summary of operation
// - 40-bit clip loads 9.31 limit, sets flag
// - 32-bit clip loads 1.31 limit, sets flag
// - 32-bit clip mode never sets guard flags
// - Unclipped mode flags bit-39 overflow, wraps
// - Trap enable lets wrap raise trap
// - Accumulate op may store other accumulator
// - Write-back to pointer or memory, pointer+2
// - Combinational round, style from control bit
// - Unrounded store truncates lower word away
// - Conventional: lower word msb increments upper
// - Convergent tie increments only when bit16 set
// - Store ops write target upper word, clipped
// - Write-back data is always rounded
// - Store clip leaves accumulator unchanged
// - Store clip forces 7FFF or 8000
// - Store clip sign taken from bit 39
// - Store clip off passes data unmodified
// - Shifter shifts up to 16, three sources
// - Signed amount: positive right, negative left
// - 40-bit and 16-bit results, bus placement
// - Clip decision uses enables and width select
// - Guard flag when bits 39..32 differ
// - Combined guard and clip flags are ORs
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`default_nettype none
module dsar_core
  import dsar_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // Decoder operation
  input wire logic op_valid_in,
  input wire logic [2:0] op_code_in,
  input wire logic op_acc_sel_in,
  input wire logic [39:0] op_operand_in,
  input wire logic op_wb_en_in,
  input wire logic op_wb_indirect_in,
  input wire logic [15:0] op_store_addr_in,
  input wire logic [1:0] shift_src_in,
  input wire logic [5:0] shift_amt_in,
  input wire logic shift_arith_in,
  input wire logic [15:0] xbus_rd_data_in,
  // X bus write and results
  output logic xbus_wr_en_out,
  output logic [15:0] xbus_wr_addr_out,
  output logic [15:0] xbus_wr_data_out,
  output logic [39:0] shift_result_out,
  output logic [15:0] shift_core_out,
  output logic catastrophic_trap_out,
  output logic any_guard_overflow_out,
  output logic any_acc_clip_out
);
  // Whole state of the block
  typedef struct packed {
    logic [1:0][39:0] acc;
    logic [CTRL_W-1:0] ctrl;
    logic [1:0] clip;
    logic [1:0] guard;
    logic [15:0] wbptr;
    logic xw_en;
    logic [15:0] xw_addr;
    logic [15:0] xw_data;
    logic [39:0] shres;
    logic [15:0] shcore;
    logic trap;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dsar_state_s;

  dsar_state_s st_ff;
  dsar_state_s nxt_st;

  // Datapath decode, visible to the checks below
  logic tgt, oth, acc_op, sat_en, wide, ovf39, ovf31, clip_set, cat_ovf;
  logic [39:0] base, addend, res;
  logic [40:0] sum;
  logic is_store, wb_do, rnd_req, inc;
  logic [39:0] src;
  logic [24:0] ext;
  logic [15:0] wdat;
  logic [1:0] clr;
  logic [5:0] mag;
  logic [39:0] sh_opnd, sh_res;
  logic aw_hs, w_hs, ar_hs;

  // Handshake outputs
  assign s_axi_awready_out = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready_out = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_arready_out = !st_ff.rvalid;
  assign aw_hs = s_axi_awvalid_in && s_axi_awready_out;
  assign w_hs = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_hs = s_axi_arvalid_in && s_axi_arready_out;

  // Accumulator adder and its saturation decision
  always_comb begin
    tgt = op_acc_sel_in;
    oth = !op_acc_sel_in;
    acc_op = op_valid_in && (op_code_in <= OP_DIFF_SQUARE_ACCUMULATE_OP);
    base = (op_code_in == OP_MAC || op_code_in == OP_DIFF_SQUARE_ACCUMULATE_OP) ? st_ff.acc[tgt] : 40'h00_0000_0000;
    addend = (op_code_in == OP_MPYN) ? 40'(-op_operand_in) : op_operand_in;
    sum = {base[39], base} + {addend[39], addend};
    ovf39 = sum[40] ^ sum[39];
    ovf31 = !((&sum[40:31]) || !(|sum[40:31]));
    sat_en = st_ff.ctrl[tgt ? CTL_CLIPB : CTL_CLIPA];
    wide = st_ff.ctrl[CTL_WIDTH];
    res = sum[39:0];
    clip_set = 1'b0;
    cat_ovf = 1'b0;
    if (sat_en && wide && ovf39) begin
      res = sum[40] ? ACC_MIN40 : ACC_MAX40;
      clip_set = 1'b1;
    end else if (sat_en && !wide && ovf31) begin
      res = sum[40] ? ACC_MIN32 : ACC_MAX32;
      clip_set = 1'b1;
    end else if (!sat_en && ovf39) begin
      clip_set = 1'b1;
      cat_ovf = 1'b1;
    end
  end

  // Round and store clip; the source accumulator is only read
  always_comb begin
    is_store = op_valid_in && (op_code_in == OP_SAC || op_code_in == OP_SACR);
    wb_do = op_valid_in && op_code_in == OP_MAC && op_wb_en_in;
    src = is_store ? st_ff.acc[tgt] : st_ff.acc[oth];
    rnd_req = wb_do || op_code_in == OP_SACR;
    if (st_ff.ctrl[CTL_RNDSTY]) begin
      inc = src[15];
    end else begin
      inc = src[15] && (src[15:0] != LOW_HALF || src[16]);
    end
    if (!rnd_req) begin
      inc = 1'b0;
    end
    ext = {src[39], src[39:16]} + {24'h00_0000, inc};
    wdat = ext[15:0];
    if (st_ff.ctrl[CTL_STCLIP]) begin
      // Sign from bit 39 catches a rounding carry that flips the sign
      if (!src[39] && (|ext[24:15])) begin
        wdat = WORD_MAX;
      end else if (src[39] && !(&ext[23:15])) begin
        wdat = WORD_MIN;
      end
    end
  end

  // Barrel shifter, amount clamped to the sixteen-bit reach
  always_comb begin
    mag = shift_amt_in[5] ? 6'(-shift_amt_in) : shift_amt_in;
    if (mag > SHIFT_MAX) begin
      mag = SHIFT_MAX;
    end
    case (dsar_shsrc_e'(shift_src_in))
      SH_ACCA: sh_opnd = st_ff.acc[0];
      SH_ACCB: sh_opnd = st_ff.acc[1];
      default: begin
        if (shift_amt_in[5]) begin
          sh_opnd = {24'h00_0000, xbus_rd_data_in};
        end else begin
          sh_opnd = {{8{shift_arith_in & xbus_rd_data_in[15]}}, xbus_rd_data_in,
                     16'h0000};
        end
      end
    endcase
    if (shift_amt_in[5]) begin
      sh_res = sh_opnd << mag;
    end else if (shift_arith_in) begin
      sh_res = 40'($signed(sh_opnd) >>> mag);
    end else begin
      sh_res = sh_opnd >> mag;
    end
  end

  // Next state: bus slave first, datapath after so it wins
  always_comb begin
    nxt_st = st_ff;
    nxt_st.xw_en = 1'b0;
    nxt_st.trap = 1'b0;
    clr = 2'b00;
    if (aw_hs) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr_in;
    end
    if (w_hs) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata_in;
      nxt_st.wstrb = s_axi_wstrb_in;
    end
    if (st_ff.bvalid && s_axi_bready_in) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_got && st_ff.w_got) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      case (st_ff.awaddr)
        ADDR_CTRL: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.ctrl = st_ff.wdata[CTRL_W-1:0];
          end
        end
        ADDR_STAT: begin
          if (st_ff.wstrb[0]) begin
            clr = {st_ff.wdata[ST_CLIPB], st_ff.wdata[ST_CLIPA]};
          end
        end
        ADDR_WBPTR: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.wbptr[7:0] = st_ff.wdata[7:0];
          end
          if (st_ff.wstrb[1]) begin
            nxt_st.wbptr[15:8] = st_ff.wdata[15:8];
          end
        end
        ADDR_ACCA_LO, ADDR_ACCA_HI, ADDR_ACCB_LO, ADDR_ACCB_HI: begin
          nxt_st.bresp = RESP_OKAY; // Read-only, write ignored
        end
        default: nxt_st.bresp = RESP_SLVERR;
      endcase
    end
    if (st_ff.rvalid && s_axi_rready_in) begin
      nxt_st.rvalid = 1'b0;
    end
    if (ar_hs) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      case (s_axi_araddr_in)
        ADDR_CTRL: nxt_st.rdata = {26'h000_0000, st_ff.ctrl};
        ADDR_STAT: nxt_st.rdata = {26'h000_0000, |st_ff.clip, |st_ff.guard,
                                   st_ff.guard, st_ff.clip};
        ADDR_ACCA_LO: nxt_st.rdata = st_ff.acc[0][31:0];
        ADDR_ACCA_HI: nxt_st.rdata = {24'h00_0000, st_ff.acc[0][39:32]};
        ADDR_ACCB_LO: nxt_st.rdata = st_ff.acc[1][31:0];
        ADDR_ACCB_HI: nxt_st.rdata = {24'h00_0000, st_ff.acc[1][39:32]};
        ADDR_WBPTR: nxt_st.rdata = {16'h0000, st_ff.wbptr};
        default: begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Software clear loses to a same-cycle hardware set
    nxt_st.clip = st_ff.clip & ~clr;
    if (acc_op) begin
      nxt_st.acc[tgt] = res;
      nxt_st.clip[tgt] = nxt_st.clip[tgt] | clip_set;
      // Guard flag follows every pass, but not in 1.31 clip mode
      nxt_st.guard[tgt] = !(sat_en && !wide) &&
                          !((&res[39:32]) || !(|res[39:32]));
      nxt_st.trap = cat_ovf && st_ff.ctrl[CTL_TRAP];
    end
    if (is_store) begin
      nxt_st.xw_en = 1'b1;
      nxt_st.xw_addr = op_store_addr_in;
      nxt_st.xw_data = wdat;
    end
    if (wb_do) begin
      if (op_wb_indirect_in) begin
        nxt_st.xw_en = 1'b1;
        nxt_st.xw_addr = st_ff.wbptr;
        nxt_st.xw_data = wdat;
        nxt_st.wbptr = st_ff.wbptr + WB_STEP;
      end else begin
        nxt_st.wbptr = wdat;
      end
    end
    if (op_valid_in && op_code_in == OP_SHIFT) begin
      nxt_st.shres = sh_res;
      nxt_st.shcore = shift_amt_in[5] ? sh_res[15:0] : sh_res[31:16];
    end
  end

  // State register
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_ff <= '0;
      st_ff.ctrl <= CTRL_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign s_axi_bvalid_out = st_ff.bvalid;
  assign s_axi_bresp_out = st_ff.bresp;
  assign s_axi_rvalid_out = st_ff.rvalid;
  assign s_axi_rdata_out = st_ff.rdata;
  assign s_axi_rresp_out = st_ff.rresp;
  assign xbus_wr_en_out = st_ff.xw_en;
  assign xbus_wr_addr_out = st_ff.xw_addr;
  assign xbus_wr_data_out = st_ff.xw_data;
  assign shift_result_out = st_ff.shres;
  assign shift_core_out = st_ff.shcore;
  assign catastrophic_trap_out = st_ff.trap;
  assign any_guard_overflow_out = |st_ff.guard;
  assign any_acc_clip_out = |st_ff.clip;

  // Checks
  default clocking dsar_cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  a_clip_sticky: assert property (st_ff.clip[0] && !clr[0] |=> st_ff.clip[0])
    else $error("clip flag A dropped without a clear");
  a_sat40_limit: assert property (acc_op && sat_en && wide && ovf39 && !tgt
    |=> (st_ff.acc[0] == ACC_MAX40 || st_ff.acc[0] == ACC_MIN40) && st_ff.clip[0])
    else $error("40-bit clip did not load limit");
  a_sat32_limit: assert property (acc_op && sat_en && !wide && ovf31 && tgt
    |=> (st_ff.acc[1] == ACC_MAX32 || st_ff.acc[1] == ACC_MIN32) && st_ff.clip[1])
    else $error("32-bit clip did not load limit");
  a_sat32_guard: assert property (acc_op && sat_en && !wide && !tgt |=> !st_ff.guard[0])
    else $error("guard flag set in 32-bit clip mode");
  a_wrap_trap: assert property (acc_op && !sat_en && ovf39 && st_ff.ctrl[CTL_TRAP]
    |=> catastrophic_trap_out)
    else $error("trap not raised after wrap");
  // Back-to-back wraps may hold the trap high, so pulse width is tied to its cause
  a_trap_cause: assert property (catastrophic_trap_out
    |-> $past(acc_op && cat_ovf && st_ff.ctrl[CTL_TRAP]))
    else $error("trap raised without an enabled wrap");
  a_wrap_value: assert property (acc_op && !sat_en && !tgt
    |=> st_ff.acc[0] == $past(sum[39:0]))
    else $error("accumulator did not wrap");
  a_wb_step: assert property (wb_do && op_wb_indirect_in
    |=> xbus_wr_en_out && st_ff.wbptr == $past(st_ff.wbptr) + WB_STEP)
    else $error("write-back pointer not stepped by two");
  a_trunc_pass: assert property (op_valid_in && op_code_in == OP_SAC && !st_ff.ctrl[CTL_STCLIP]
    |=> xbus_wr_data_out == $past(src[31:16]))
    else $error("unclipped truncated store altered");
  a_clip_pos: assert property (is_store && st_ff.ctrl[CTL_STCLIP] && !src[39] && |src[38:31]
    |=> xbus_wr_data_out == WORD_MAX)
    else $error("store clip did not force maximum");
  // A rounding step cannot lift a word this far below the limit back into range
  a_clip_neg: assert property (is_store && st_ff.ctrl[CTL_STCLIP] && src[39] &&
    !(&src[38:32]) |=> xbus_wr_data_out == WORD_MIN)
    else $error("store clip did not force minimum");
  a_guard_track: assert property (acc_op && !tgt && !(sat_en && !wide)
    |=> st_ff.guard[0] == (st_ff.acc[0][39:32] != {8{st_ff.acc[0][39]}}))
    else $error("guard flag does not match guard bits");
  a_shift_zero: assert property (op_valid_in && op_code_in == OP_SHIFT
    && shift_src_in == SH_ACCA && shift_amt_in == 6'h00
    |=> shift_result_out == $past(st_ff.acc[0]))
    else $error("zero shift changed operand");
endmodule
`default_nettype wire

// ---- dv/dsar_xmem.sv ----
// Purpose: X bus data memory on the far side of the accumulator back end
// Assumes: Word writes only; 16 words decoded from address bits 4:1
// Notes: Read port is combinational, like a register file read port
`default_nettype none
module dsar_xmem (
  // Clock
  input wire logic mclk_in,
  // Write side from the core
  input wire logic wr_en_in,
  input wire logic [15:0] wr_addr_in,
  input wire logic [15:0] wr_data_in,
  // Read side
  input wire logic [3:0] rd_sel_in,
  output logic [15:0] rd_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16];
  // Unwritten words hold a pattern, so a missing write cannot pass as zero
  initial foreach (mem[i]) mem[i] = 16'h5A5A ^ 16'(i);
  // Capture each write pulse
  always @(posedge mclk_in) begin
    if (wr_en_in === 1'b1) begin
      mem[wr_addr_in[4:1]] <= wr_data_in;
    end
  end
  assign rd_data_out = mem[rd_sel_in];
endmodule
`default_nettype wire

// ---- dv/dsar_core_tb.sv ----
// Purpose: Self-checking bench for the accumulator back end
// Assumes: Inputs change by non-blocking assignment after a rising edge
// Notes: Outputs are sampled on the falling edge, where they are settled
`default_nettype none
module dsar_core_tb;
  import dsar_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] ctl; logic [2:0] code; logic [39:0] acc; logic [15:0] exp;
  } dsar_row_s;
  typedef struct packed {
    logic [1:0] src; logic [5:0] amt; logic ar; logic [3:0] m; logic [39:0] r; logic [15:0] c;
  } dsar_shrow_s;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic opv = 0, sel = 0, wbe = 0, wbi = 0, sha = 0;
  logic awr, wr, bv, arr, rv, xwe, trap, anyg, anyc;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0] wst = 0, rsel = 0;
  logic [1:0] br, rr, shs = 0;
  logic [2:0] opc = 0;
  logic [39:0] opd = 0, shr;
  logic [15:0] sta = 0, xwa, xwd, xrd, shc;
  logic [5:0] sham = 0;
  int num_errors = 0, total_checks = 0;
  // Store cases: control, store op, accumulator, word expected on the X bus
  dsar_row_s rows [8] = '{
    '{8'h10, OP_SACR, 40'h00_1234_8000, 16'h1235}, '{8'h10, OP_SACR, 40'h00_1234_7FFF, 16'h1234},
    '{8'h00, OP_SACR, 40'h00_1234_8000, 16'h1234}, '{8'h00, OP_SACR, 40'h00_1235_8000, 16'h1236},
    '{8'h10, OP_SAC, 40'h00_1234_FFFF, 16'h1234}, '{8'h00, OP_SAC, 40'h01_2345_0000, 16'h2345},
    '{8'h08, OP_SAC, 40'h01_0000_0000, 16'h7FFF}, '{8'h08, OP_SACR, 40'hFE_0000_0000, 16'h8000}};
  // Shift cases; word 7 holds 8000 and word 0 holds 1235 after the store loop
  dsar_shrow_s shrows [7] = '{
    '{SH_XBUS, 6'h04, 1'b1, 4'h7, 40'hFF_F800_0000, 16'hF800},
    '{SH_XBUS, 6'h04, 1'b0, 4'h7, 40'h00_0800_0000, 16'h0800},
    '{SH_XBUS, 6'h3C, 1'b0, 4'h0, 40'h00_0001_2350, 16'h2350},
    '{SH_XBUS, 6'h00, 1'b0, 4'h0, 40'h00_1235_0000, 16'h1235},
    '{SH_XBUS, 6'h10, 1'b0, 4'h7, 40'h00_0000_8000, 16'h0000},
    '{SH_ACCB, 6'h30, 1'b0, 4'h0, 40'h00_8000_0000, 16'h0000},
    '{SH_ACCA, 6'h00, 1'b0, 4'h0, 40'h80_0000_0000, 16'h0000}};
  logic [2:0] nowb [4] = '{OP_MPY, OP_MPYN, OP_ED, OP_DIFF_SQUARE_ACCUMULATE_OP};

  dsar_core uut (.mclk_in(clk), .reset_in(rst),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(wst),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_bresp_out(br),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
    .op_valid_in(opv), .op_code_in(opc), .op_acc_sel_in(sel), .op_operand_in(opd),
    .op_wb_en_in(wbe), .op_wb_indirect_in(wbi), .op_store_addr_in(sta),
    .shift_src_in(shs), .shift_amt_in(sham), .shift_arith_in(sha), .xbus_rd_data_in(xrd),
    .xbus_wr_en_out(xwe), .xbus_wr_addr_out(xwa), .xbus_wr_data_out(xwd),
    .shift_result_out(shr), .shift_core_out(shc), .catastrophic_trap_out(trap),
    .any_guard_overflow_out(anyg), .any_acc_clip_out(anyc));
  dsar_xmem xmem (.mclk_in(clk), .wr_en_in(xwe), .wr_addr_in(xwa), .wr_data_in(xwd),
    .rd_sel_in(rsel), .rd_data_out(xrd));

  // Clock, 100 ns period
  initial forever #50 clk = ~clk;

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data offered together; each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    logic ad, wk, ah, wh;
    @(posedge clk);
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= d;
    wst <= 4'hF;
    bry <= 1;
    ad = 0;
    wk = 0;
    while (!(ad && wk)) begin
      @(negedge clk);
      ah = !ad && awr;
      wh = !wk && wr;
      @(posedge clk);
      if (ah) awv <= 0;
      if (wh) wv <= 0;
      ad = ad | ah;
      wk = wk | wh;
    end
    do @(negedge clk); while (bv !== 1'b1);
    chk(40'(br), 40'(e));
    @(posedge clk);
    bry <= 0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arv <= 1;
    ara <= a;
    rry <= 1;
    do @(negedge clk); while (arr !== 1'b1);
    @(posedge clk);
    arv <= 0;
    do @(negedge clk); while (rv !== 1'b1);
    d = rd;
    r = rr;
    @(posedge clk);
    rry <= 0;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(40'({r, d}), 40'({RESP_OKAY, e}));
  endtask
  task automatic chk_acc(input logic b, input logic [39:0] e);
    logic [31:0] lo, hi;
    logic [1:0] r;
    axi_rd(b ? ADDR_ACCB_LO : ADDR_ACCA_LO, lo, r);
    axi_rd(b ? ADDR_ACCB_HI : ADDR_ACCA_HI, hi, r);
    chk({hi[7:0], lo}, e);
  endtask
  // One operation; ends on the falling edge where its results are visible
  task automatic op(input logic [2:0] c, input logic s, input logic [39:0] v,
      input logic w = 0, input logic i = 0, input logic [15:0] a = 0);
    @(posedge clk);
    opv <= 1;
    opc <= c;
    sel <= s;
    opd <= v;
    wbe <= w;
    wbi <= i;
    sta <= a;
    @(posedge clk);
    opv <= 0;
    @(negedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2_000_000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end

  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (6) @(posedge clk);
    rst <= 0;
    chk_reg(ADDR_CTRL, 32'h0);
    chk_reg(ADDR_STAT, 32'h0);
    axi_rd(8'h40, d, r);
    chk(40'({r, d}), 40'({RESP_SLVERR, 32'h0}));
    axi_wr(8'h40, 32'h0, RESP_SLVERR);
    $display("test reset and bus done");
    foreach (rows[k]) begin
      axi_wr(ADDR_CTRL, 32'(rows[k].ctl));
      op(OP_MPY, k[0], rows[k].acc);
      op(rows[k].code, k[0], 40'h0, 0, 0, 16'(k * 2));
      chk(40'({xwe, xwa, xwd}), 40'({1'b1, 16'(k * 2), rows[k].exp}));
    end
    chk_acc(0, 40'h01_0000_0000);
    chk_acc(1, 40'hFE_0000_0000);
    $display("test store and round done");
    // Unclipped wrap with the trap enabled
    op(OP_MPY, 1, 40'h0);
    axi_wr(ADDR_CTRL, 32'h20);
    op(OP_MPY, 0, ACC_MAX40);
    op(OP_MAC, 0, 40'h1);
    chk(40'({trap, anyc, anyg}), 40'h7);
    chk_acc(0, ACC_MIN40);
    chk_reg(ADDR_STAT, 32'h35);
    op(OP_MPY, 0, 40'h1);
    chk_reg(ADDR_STAT, 32'h21);
    axi_wr(ADDR_STAT, 32'h1);
    chk_reg(ADDR_STAT, 32'h0);
    $display("test wrap done");
    // 40-bit clip on both limits
    axi_wr(ADDR_CTRL, 32'h05);
    op(OP_MPY, 0, ACC_MAX40);
    op(OP_MAC, 0, 40'h1);
    chk_acc(0, ACC_MAX40);
    op(OP_MPY, 0, ACC_MIN40);
    op(OP_MAC, 0, 40'hFF_FFFF_FFFF);
    chk_acc(0, ACC_MIN40);
    chk_reg(ADDR_STAT, 32'h35);
    // 32-bit clip, overflowing deep into the guard bits
    axi_wr(ADDR_STAT, 32'h1);
    axi_wr(ADDR_CTRL, 32'h03);
    op(OP_MPY, 0, ACC_MAX32);
    op(OP_MAC, 0, 40'h01_0000_0000);
    chk_acc(0, ACC_MAX32);
    op(OP_MPY, 1, ACC_MIN32);
    op(OP_MAC, 1, 40'hFF_0000_0000);
    chk_acc(1, ACC_MIN32);
    chk_reg(ADDR_STAT, 32'h23);
    $display("test clip modes done");
    // Write-back of the other accumulator, always rounded
    axi_wr(ADDR_STAT, 32'h3);
    axi_wr(ADDR_CTRL, 32'h10);
    axi_wr(ADDR_WBPTR, 32'h30);
    op(OP_MPY, 1, 40'h00_4000_8000);
    op(OP_MAC, 0, 40'h0, 1, 1);
    chk(40'({xwe, xwa, xwd}), 40'({1'b1, 16'h0030, 16'h4001}));
    chk_reg(ADDR_WBPTR, 32'h32);
    op(OP_MAC, 0, 40'h0, 1, 0);
    chk_reg(ADDR_WBPTR, 32'h4001);
    foreach (nowb[k]) begin
      op(nowb[k], 0, 40'h0, 1, 1);
      chk(40'(xwe), 40'h0);
    end
    $display("test write-back done");
    // Shifter over all three sources and both directions
    op(OP_MPY, 0, 40'h80_0000_0000);
    foreach (shrows[k]) begin
      @(posedge clk);
      shs <= shrows[k].src;
      sham <= shrows[k].amt;
      sha <= shrows[k].ar;
      rsel <= shrows[k].m;
      op(OP_SHIFT, 0, 40'h0);
      chk(shr, shrows[k].r);
      chk(40'(shc), 40'(shrows[k].c));
    end
    @(posedge clk);
    shs <= SH_ACCA;
    sham <= 6'h04;
    sha <= 1;
    op(OP_SHIFT, 0, 40'h0);
    chk(shr, 40'hF8_0000_0000);
    $display("test shifter done");
    // Mid-run reset clears control, flags and accumulators
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    chk_reg(ADDR_CTRL, 32'h0);
    chk_reg(ADDR_STAT, 32'h0);
    chk_acc(1, 40'h0);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
`default_nettype wire
